// [hw/eprr_pkg.sv]
// shared constants and carriers for the page rights restriction leaf
package eprr_pkg;
  // =====================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LEAF = 8'h04;
  localparam logic [7:0] OFS_DPTR_LO = 8'h08;
  localparam logic [7:0] OFS_DPTR_HI = 8'h0c;
  localparam logic [7:0] OFS_TPTR_LO = 8'h10;
  localparam logic [7:0] OFS_TPTR_HI = 8'h14;
  localparam logic [7:0] OFS_LIMIT = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_FLAGS = 8'h20;
  localparam logic [7:0] OFS_RESULT = 8'h24;
  localparam logic [7:0] OFS_MAP_IDX = 8'h28;
  localparam logic [7:0] OFS_MAP_DATA = 8'h2c;
  localparam logic [7:0] OFS_ENCL = 8'h30;
  localparam logic [7:0] OFS_FADDR_LO = 8'h34;
  localparam logic [7:0] OFS_FADDR_HI = 8'h38;
  localparam logic [7:0] OFS_DESC = 8'h40;
  // =====================================
  // field positions and codes
  localparam int CTRL_GO = 0;
  localparam int CTRL_PROT = 1;
  localparam int CTRL_LONG = 2;
  localparam int CTRL_CPL = 4;
  localparam int ENCL_INIT = 0;
  localparam int ENCL_DRD = 1;
  localparam int ENCL_TRW = 2;
  localparam logic [7:0] LEAF_RESTRICT = 8'h0e;
  localparam logic [1:0] FK_NONE = 2'h0;
  localparam logic [1:0] FK_GP = 2'h1;
  localparam logic [1:0] FK_PF = 2'h2;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] RST_ENCL = 32'h0000_0006;
  localparam int DESC_WORDS = 16;
  localparam logic [4:0] COPY_LAST = 5'h0f;
  localparam logic [5:0] DESC_ALIGN_MASK = 6'h3f;
  localparam logic [11:0] PAGE_ALIGN_MASK = 12'hfff;
  localparam int PAGE_SHIFT = 12;
  // =====================================
  // carriers
  typedef struct packed {
    logic valid;
    logic [7:0] ptype;
    logic [1:0] spare;
    logic pr;
    logic modified;
    logic pending;
    logic [2:0] access_right_bits;
  } eprr_entry_t;
  typedef struct packed {
    logic sf;
    logic zf;
    logic af;
    logic pf;
    logic of;
    logic cf;
  } eprr_flags_t;
  typedef enum {ST_IDLE, ST_CHECK, ST_COPY, ST_EVAL} eprr_state_t;
endpackage

// [hw/eprr_restrict.sv]
// page rights restriction leaf with axi4-lite register access
// =====================================
// How it works
// R1: leaf runs when go is issued with selector 0eh
// R2: descriptor rwx bits act only as a narrowing mask
// R3: privilege level other than zero is refused with a protection fault
// R4: descriptor pointer off a 64-byte boundary gives protection fault, code zero
// R5: target pointer off a 4-kilobyte boundary gives protection fault, code zero
// R6: target outside the page cache region gives a page fault
// R7: nonzero reserved fields or read-clear-write-set mask give protection fault
// R8: first-generation or other second-generation access gives protection fault
// R9: invalid map entry gives a page fault on the target
// R10: second-generation holder gives zero flag, conflict code, no update
// R11: pending or modified page gives zero flag, not-modifiable code
// R12: page type other than regular gives a page fault
// R13: owning enclave not initialized gives protection fault
// R14: success sets restriction pending then ands rights with mask
// R15: every end clears cf pf af of sf; success clears zf, result zero
// R16: page held exclusively while the leaf runs; o_hold is raised only in the copy and eval states, not in the check cycle
// R17: protected mode address beyond segment limit gives protection fault
// R18: non-canonical address in 64-bit mode gives protection fault
// R19: operand locked by another agent gives protection fault
// R20: full 512-bit descriptor copied to scratch before any field is read
// R21: descriptor readable outside enclave, target read-write inside, else fault
// R22: checks run in order, first failure wins, faults leave map intact
`timescale 1ns/100ps
module eprr_restrict import eprr_pkg::*; #(
  parameter int PAGES = 16,
  parameter logic [63:0] EPC_BASE = 64'h0,
  parameter logic [7:0] REG_TYPE = 8'h01,
  parameter logic [31:0] CONFLICT_CODE = 32'h0000_0001,
  parameter logic [31:0] NOTMOD_CODE = 32'h0000_0002
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_gen1_access,
  input wire logic i_gen2_access,
  input wire logic i_gen2_hold,
  input wire logic i_op_locked,
  output logic o_busy,
  output logic o_hold,
  output logic [$clog2(PAGES)-1:0] o_hold_page
);
  localparam int IW = $clog2(PAGES);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic noncanon(input logic [63:0] a);
    return !((&a[63:47]) || !(|a[63:47]));
  endfunction

  // =====================================
  // synchronisers for outside agents
  logic [3:0] pin_s1_r, pin_s2_r;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else begin
      pin_s1_r <= {i_op_locked, i_gen2_hold, i_gen2_access, i_gen1_access};
      pin_s2_r <= pin_s1_r;
    end
  end
  wire gen1_s = pin_s2_r[0];
  wire gen2_s = pin_s2_r[1];
  wire hold_s = pin_s2_r[2];
  wire lock_s = pin_s2_r[3];

  // =====================================
  // axi4-lite handshake
  eprr_state_t st_r;
  logic wr_go;
  logic [7:0] rd_addr;
  assign wr_go = i_awvalid && i_wvalid && !o_bvalid;
  assign o_awready = wr_go;
  assign o_wready = wr_go;
  assign o_arready = !o_rvalid;

  // =====================================
  // software registers
  logic [31:0] ctrl_r, leaf_r, limit_r, encl_r, idx_r;
  logic [63:0] dptr_r, tptr_r;
  logic [31:0] stage_r [DESC_WORDS];
  logic go_pulse;
  wire idle = (st_r == ST_IDLE);
  wire wdesc = i_awaddr >= OFS_DESC;
  wire [3:0] wslot = i_awaddr[5:2];
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= RST_WORD;
      leaf_r <= RST_WORD;
      limit_r <= RST_WORD;
      encl_r <= RST_ENCL;
      idx_r <= RST_WORD;
      dptr_r <= {RST_WORD, RST_WORD};
      tptr_r <= {RST_WORD, RST_WORD};
      go_pulse <= 1'b0;
      for (int i = 0; i < DESC_WORDS; i++) begin
        stage_r[i] <= RST_WORD;
      end
    end else begin
      go_pulse <= 1'b0;
      // operands are frozen while the leaf runs
      if (wr_go && idle) begin
        case (i_awaddr)
          OFS_CTRL: begin
            ctrl_r <= merge(ctrl_r, i_wdata, i_wstrb);
            go_pulse <= i_wstrb[0] && i_wdata[CTRL_GO];
          end
          OFS_LEAF: leaf_r <= merge(leaf_r, i_wdata, i_wstrb);
          OFS_DPTR_LO: dptr_r[31:0] <= merge(dptr_r[31:0], i_wdata, i_wstrb);
          OFS_DPTR_HI: dptr_r[63:32] <= merge(dptr_r[63:32], i_wdata, i_wstrb);
          OFS_TPTR_LO: tptr_r[31:0] <= merge(tptr_r[31:0], i_wdata, i_wstrb);
          OFS_TPTR_HI: tptr_r[63:32] <= merge(tptr_r[63:32], i_wdata, i_wstrb);
          OFS_LIMIT: limit_r <= merge(limit_r, i_wdata, i_wstrb);
          OFS_ENCL: encl_r <= merge(encl_r, i_wdata, i_wstrb);
          OFS_MAP_IDX: idx_r <= merge(idx_r, i_wdata, i_wstrb);
          default: begin
            if (wdesc) begin
              stage_r[wslot] <= merge(stage_r[wslot], i_wdata, i_wstrb);
            end
          end
        endcase
      end
    end
  end

  // =====================================
  // first-stage checks, in order
  logic [1:0] fk_nxt;
  logic [63:0] fa_nxt;
  wire [63:0] toff = tptr_r - EPC_BASE;
  wire in_epc = (tptr_r >= EPC_BASE) && (toff[63:PAGE_SHIFT] < 52'(PAGES));
  wire [IW-1:0] pidx = toff[PAGE_SHIFT +: IW];
  wire lim_bad = ctrl_r[CTRL_PROT] && !ctrl_r[CTRL_LONG] &&
                 (dptr_r[31:0] > limit_r || tptr_r[31:0] > limit_r);
  always_comb begin
    fk_nxt = FK_NONE;
    fa_nxt = 64'h0;
    // R1: only the restrict selector runs
    if (leaf_r[7:0] != LEAF_RESTRICT) fk_nxt = FK_GP;
    // R3: ring zero only
    else if (ctrl_r[CTRL_CPL +: 2] != 2'h0) fk_nxt = FK_GP;
    // R18: canonical pointers
    else if (ctrl_r[CTRL_LONG] && (noncanon(dptr_r) || noncanon(tptr_r))) fk_nxt = FK_GP;
    // R17: segment limit
    else if (lim_bad) fk_nxt = FK_GP;
    // R19: locked operand
    else if (lock_s) fk_nxt = FK_GP;
    // R4: descriptor alignment
    else if ((dptr_r[5:0] & DESC_ALIGN_MASK) != 6'h0) fk_nxt = FK_GP;
    // R5: page alignment
    else if ((tptr_r[11:0] & PAGE_ALIGN_MASK) != 12'h0) fk_nxt = FK_GP;
    // R6: target in page cache
    else if (!in_epc) begin
      fk_nxt = FK_PF;
      fa_nxt = tptr_r;
    end
    // R21: access terms
    else if (!encl_r[ENCL_DRD]) begin
      fk_nxt = FK_PF;
      fa_nxt = dptr_r;
    end else if (!encl_r[ENCL_TRW]) begin
      fk_nxt = FK_PF;
      fa_nxt = tptr_r;
    end
  end

  // =====================================
  // leaf sequencer and results
  logic [4:0] cnt_r;
  logic [511:0] scratch_r;
  logic [IW-1:0] page_r;
  logic [1:0] fault_r;
  logic [63:0] faddr_r;
  logic [31:0] result_r;
  eprr_flags_t flags_r;
  logic done_r;
  eprr_entry_t map_r [PAGES];
  eprr_entry_t ent;
  assign ent = map_r[page_r];
  wire [2:0] mask = scratch_r[2:0];
  wire rsvd_bad = (scratch_r[511:16] != 496'h0) || (scratch_r[7:3] != 5'h0);
  wire upd = (st_r == ST_EVAL) && !rsvd_bad && !(!mask[0] && mask[1]) && !gen1_s &&
             !gen2_s && ent.valid && !hold_s && !ent.pending && !ent.modified &&
             ent.ptype == REG_TYPE && encl_r[ENCL_INIT];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= ST_IDLE;
      cnt_r <= 5'h0;
      scratch_r <= 512'h0;
      page_r <= '0;
      fault_r <= FK_NONE;
      faddr_r <= 64'h0;
      result_r <= RST_WORD;
      flags_r <= '0;
      done_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (go_pulse) begin
            st_r <= ST_CHECK;
            done_r <= 1'b0;
          end
        end
        ST_CHECK: begin
          page_r <= pidx;
          cnt_r <= 5'h0;
          fault_r <= fk_nxt;
          faddr_r <= fa_nxt;
          // R15: arithmetic flags cleared on every end
          flags_r <= '0;
          if (fk_nxt != FK_NONE) begin
            st_r <= ST_IDLE;
            done_r <= 1'b1;
          end else begin
            st_r <= ST_COPY;
          end
        end
        ST_COPY: begin
          // R20: whole descriptor into scratch first
          scratch_r[cnt_r[3:0]*32 +: 32] <= stage_r[cnt_r[3:0]];
          cnt_r <= cnt_r + 5'h1;
          if (cnt_r == COPY_LAST) st_r <= ST_EVAL;
        end
        ST_EVAL: begin
          st_r <= ST_IDLE;
          done_r <= 1'b1;
          // R22: first failing check decides
          // R7: reserved fields and mask shape
          if (rsvd_bad || (!mask[0] && mask[1])) fault_r <= FK_GP;
          // R8: other leaves on the page
          else if (gen1_s || gen2_s) fault_r <= FK_GP;
          // R9: entry must be valid
          else if (!ent.valid) begin
            fault_r <= FK_PF;
            faddr_r <= tptr_r;
          end
          // R10: page conflict
          else if (hold_s) begin
            flags_r.zf <= 1'b1;
            result_r <= CONFLICT_CODE;
          end
          // R11: not modifiable
          else if (ent.pending || ent.modified) begin
            flags_r.zf <= 1'b1;
            result_r <= NOTMOD_CODE;
          end
          // R12: regular pages only
          else if (ent.ptype != REG_TYPE) begin
            fault_r <= FK_PF;
            faddr_r <= tptr_r;
          end
          // R13: enclave must be initialized
          else if (!encl_r[ENCL_INIT]) fault_r <= FK_GP;
          else begin
            // R15: success clears zf and result
            flags_r.zf <= 1'b0;
            result_r <= 32'h0;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // =====================================
  // page map store
  wire mapw = wr_go && idle && i_awaddr == OFS_MAP_DATA;
  wire [31:0] map_mrg = merge(32'(map_r[idx_r[IW-1:0]]), i_wdata, i_wstrb);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < PAGES; i++) begin
        map_r[i] <= '0;
      end
    end else if (upd) begin
      // R14: restriction pending bit pr set, rights narrowed
      // R2: mask can only clear rights
      map_r[page_r].pr <= 1'b1;
      map_r[page_r].access_right_bits <= map_r[page_r].access_right_bits & mask;
    end else if (mapw) begin
      map_r[idx_r[IW-1:0]] <= eprr_entry_t'(map_mrg[$bits(eprr_entry_t)-1:0]);
    end
  end

  // R16: exclusive hold while the leaf owns the page
  assign o_busy = !idle;
  assign o_hold = (st_r == ST_COPY) || (st_r == ST_EVAL);
  assign o_hold_page = page_r;

  // =====================================
  // axi responses
  logic [31:0] rd_val;
  logic rd_ok;
  assign rd_addr = i_araddr;
  always_comb begin
    rd_ok = 1'b1;
    rd_val = 32'h0;
    case (rd_addr)
      OFS_CTRL: rd_val = ctrl_r & ~32'h1;
      OFS_LEAF: rd_val = leaf_r;
      OFS_DPTR_LO: rd_val = dptr_r[31:0];
      OFS_DPTR_HI: rd_val = dptr_r[63:32];
      OFS_TPTR_LO: rd_val = tptr_r[31:0];
      OFS_TPTR_HI: rd_val = tptr_r[63:32];
      OFS_LIMIT: rd_val = limit_r;
      OFS_STATUS: rd_val = {28'h0, fault_r, done_r, !idle};
      OFS_FLAGS: rd_val = {24'h0, flags_r.sf, flags_r.zf, 1'b0, flags_r.af,
                           1'b0, flags_r.pf, 1'b0, flags_r.cf} | {20'h0, flags_r.of, 11'h0};
      OFS_RESULT: rd_val = result_r;
      OFS_MAP_IDX: rd_val = idx_r;
      OFS_MAP_DATA: rd_val = 32'(map_r[idx_r[IW-1:0]]);
      OFS_ENCL: rd_val = encl_r;
      OFS_FADDR_LO: rd_val = faddr_r[31:0];
      OFS_FADDR_HI: rd_val = faddr_r[63:32];
      default: begin
        rd_ok = rd_addr >= OFS_DESC;
        rd_val = rd_ok ? stage_r[rd_addr[5:2]] : 32'h0;
      end
    endcase
  end
  wire wr_ok = (i_awaddr <= OFS_ENCL) && i_awaddr != OFS_STATUS &&
               i_awaddr != OFS_FLAGS && i_awaddr != OFS_RESULT || wdesc;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OK;
      o_rvalid <= 1'b0;
      o_rresp <= RESP_OK;
      o_rdata <= 32'h0;
    end else begin
      if (wr_go) begin
        o_bvalid <= 1'b1;
        o_bresp <= (wr_ok && i_awaddr[1:0] == 2'h0) ? RESP_OK : RESP_SLVERR;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rdata <= rd_val;
        o_rresp <= (rd_ok && rd_addr[1:0] == 2'h0) ? RESP_OK : RESP_SLVERR;
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // =====================================
  // assertions
  sequence s_start;
    st_r == ST_CHECK && fk_nxt == FK_NONE;
  endsequence
  sequence s_eval;
    st_r == ST_EVAL;
  endsequence
  a_copy_len: assert property (@(posedge i_clk) disable iff (i_rst) // R20
    s_start |=> (st_r == ST_COPY) [*8] ##1 (st_r == ST_COPY) [*8] ##1 s_eval)
    else $error("copy phase length wrong");
  a_leaf_sel: assert property (@(posedge i_clk) disable iff (i_rst) // R1
    st_r == ST_CHECK && leaf_r[7:0] != LEAF_RESTRICT |=> fault_r == FK_GP && idle)
    else $error("wrong selector not refused");
  a_cpl_zero: assert property (@(posedge i_clk) disable iff (i_rst) // R3
    st_r == ST_CHECK && ctrl_r[CTRL_CPL +: 2] != 2'h0 |=> fault_r == FK_GP)
    else $error("nonzero privilege ran");
  a_align_gp: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    st_r == ST_CHECK && dptr_r[5:0] != 6'h0 |=> fault_r != FK_NONE && done_r)
    else $error("misaligned descriptor accepted");
  a_page_align: assert property (@(posedge i_clk) disable iff (i_rst) // R5
    st_r == ST_CHECK && tptr_r[11:0] != 12'h0 |=> fault_r != FK_NONE)
    else $error("misaligned target accepted");
  a_conflict_zf: assert property (@(posedge i_clk) disable iff (i_rst) // R10
    s_eval ##0 (!rsvd_bad && !(!mask[0] && mask[1]) && !gen1_s && !gen2_s && ent.valid &&
    hold_s) |=> flags_r.zf && result_r == CONFLICT_CODE && fault_r == FK_NONE)
    else $error("conflict path");
  a_rights_and: assert property (@(posedge i_clk) disable iff (i_rst) // R14
    upd |=> map_r[page_r].pr && map_r[page_r].access_right_bits == ($past(ent.access_right_bits) & $past(mask)))
    else $error("rights not narrowed");
  a_fault_keeps: assert property (@(posedge i_clk) disable iff (i_rst) // R22
    s_eval and !upd |=> map_r[page_r] == $past(ent))
    else $error("map changed on failure");
  a_flags_clr: assert property (@(posedge i_clk) disable iff (i_rst) // R15
    $rose(done_r) |-> !flags_r.cf && !flags_r.pf && !flags_r.af && !flags_r.of &&
    !flags_r.sf && (fault_r != FK_NONE || flags_r.zf || result_r == 32'h0))
    else $error("flags not cleared");
  a_hold_page: assert property (@(posedge i_clk) disable iff (i_rst) // R16
    s_start |=> o_hold && o_hold_page == $past(pidx))
    else $error("page not held");
endmodule

// [testbench/tb_eprr_restrict.sv]
// self-checking bench for the page rights restriction leaf
`timescale 1ns/100ps
module tb_eprr_restrict import eprr_pkg::*; ;
  // =====================================
  // signals
  logic i_clk;
  logic i_rst;
  logic [7:0] awaddr;
  logic [7:0] araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [3:0] pins;
  logic awready, wready, bvalid, arready, rvalid, busy, hld;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  logic [3:0] hpage;
  int num_errors;
  int check_count;
  // per-case operands and expectations
  logic [31:0] sel, ctl, dlo, dhi, tlo, lim, dsc, d15, enc, mpv, em, er, fa, s, d;
  logic [1:0] ef;
  logic [3:0] pv;
  logic ez;

  eprr_restrict u_eprr_restrict (
    .i_clk(i_clk), .i_rst(i_rst),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_gen1_access(pins[0]), .i_gen2_access(pins[1]), .i_gen2_hold(pins[2]),
    .i_op_locked(pins[3]), .o_busy(busy), .o_hold(hld), .o_hold_page(hpage)
  );

  // =====================================
  // clock and watchdog
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // 25 runs of some 50 to 70 cycles each; generous margin
  initial begin
    repeat (40000) @(posedge i_clk);
    num_errors++;
    complete_run;
  end

  // =====================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] rs);
    int n;
    n = 0;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin @(negedge i_clk); n++; end while ((awready & wready) !== 1'b1 && n < 200);
    @(posedge i_clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin @(negedge i_clk); n++; end while (bvalid !== 1'b1 && n < 200);
    chk({29'h0, bvalid, bresp}, {29'h0, 1'b1, rs});
    @(posedge i_clk);
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v, input logic [1:0] rs);
    int n;
    n = 0;
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin @(negedge i_clk); n++; end while (arready !== 1'b1 && n < 200);
    @(posedge i_clk);
    arvalid <= 1'b0;
    do begin @(negedge i_clk); n++; end while (rvalid !== 1'b1 && n < 200);
    v = rdata;
    chk({29'h0, rvalid, rresp}, {29'h0, 1'b1, rs});
    @(posedge i_clk);
    rready <= 1'b0;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // =====================================
  // one leaf run from a baseline with at most two operand changes
  task automatic run_case(input int k);
    int n;
    sel = {24'h0, LEAF_RESTRICT};
    ctl = 32'h1;
    dlo = 32'h40;
    dhi = 32'h0;
    tlo = 32'h2000;
    lim = 32'hffff_ffff;
    dsc = 32'h1;
    d15 = 32'h0;
    enc = 32'h7;
    mpv = 32'h0001_0107;
    pv = 4'h0;
    ef = FK_GP;
    ez = 1'b0;
    er = 32'h0;
    fa = 32'h2000;
    case (k)
      1: sel = 32'h0d;
      2: ctl = 32'h11;
      3: dlo = 32'h48;
      4: tlo = 32'h2800;
      5: begin tlo = 32'h10000; fa = tlo; ef = FK_PF; end
      6: d15 = 32'h1;
      7: dsc = 32'h2;
      8: pv = 4'h1;
      9: pv = 4'h2;
      10: begin mpv = 32'h0; ef = FK_PF; end
      11: begin pv = 4'h4; ef = FK_NONE; ez = 1'b1; er = 32'h1; end
      12: begin mpv = 32'h0001_010f; ef = FK_NONE; ez = 1'b1; er = 32'h2; end
      13: begin mpv = 32'h0001_0117; ef = FK_NONE; ez = 1'b1; er = 32'h2; end
      14: begin mpv = 32'h0001_0207; ef = FK_PF; end
      15: enc = 32'h6;
      16: begin ctl = 32'h3; lim = 32'h3f; end
      17: begin ctl = 32'h5; dhi = 32'h0000_8000; end
      18: pv = 4'h8;
      19: begin enc = 32'h5; fa = dlo; ef = FK_PF; end
      20: begin enc = 32'h3; ef = FK_PF; end
      21: begin d15 = 32'h1; mpv = 32'h0; end
      22: begin ef = FK_NONE; end
      23: begin mpv = 32'h0001_0105; dsc = 32'h7; ef = FK_NONE; end
      24: begin dsc = 32'h4; ef = FK_NONE; end
      default: begin dsc = 32'h0; ef = FK_NONE; end
    endcase
    em = mpv;
    if (ef == FK_NONE && !ez) begin
      em = {mpv[31:6], 1'b1, mpv[4:3], mpv[2:0] & dsc[2:0]};
    end
    pins <= pv;
    axw(OFS_LEAF, sel, RESP_OK);
    axw(OFS_DPTR_LO, dlo, RESP_OK);
    axw(OFS_DPTR_HI, dhi, RESP_OK);
    axw(OFS_TPTR_LO, tlo, RESP_OK);
    axw(OFS_LIMIT, lim, RESP_OK);
    axw(OFS_ENCL, enc, RESP_OK);
    axw(OFS_MAP_IDX, 32'h2, RESP_OK);
    axw(OFS_MAP_DATA, mpv, RESP_OK);
    axw(OFS_DESC, dsc, RESP_OK);
    axw(OFS_DESC + 8'h3c, d15, RESP_OK);
    // pins pass two sync stages before the leaf looks at them
    repeat (3) @(posedge i_clk);
    axw(OFS_CTRL, ctl, RESP_OK);
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    if (ef == FK_NONE) begin
      chk({31'h0, busy}, 32'h1);
      chk({31'h0, hld}, 32'h1);
      chk({28'h0, hpage}, 32'h2);
    end
    n = 0;
    do begin axr(OFS_STATUS, s, RESP_OK); n++; end while (s[1:0] !== 2'b10 && n < 60);
    chk({28'h0, s[3:0]}, {28'h0, ef, 2'b10});
    chk({30'h0, busy, hld}, 32'h0);
    axr(OFS_FLAGS, d, RESP_OK);
    chk(d & 32'h895, 32'h0);
    if (ef == FK_NONE) begin
      chk({31'h0, d[6]}, {31'h0, ez});
      axr(OFS_RESULT, d, RESP_OK);
      chk(d, er);
    end
    if (ef == FK_PF) begin
      axr(OFS_FADDR_LO, d, RESP_OK);
      chk(d, fa);
    end
    axr(OFS_MAP_DATA, d, RESP_OK);
    chk(d, em);
  endtask

  // =====================================
  // main sequence
  initial begin
    num_errors = 0;
    check_count = 0;
    i_rst = 1'b1;
    awaddr = 8'h0;
    araddr = 8'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hf;
    pins = 4'h0;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    axr(OFS_CTRL, d, RESP_OK);
    chk(d, RST_WORD);
    axr(OFS_ENCL, d, RESP_OK);
    chk(d, RST_ENCL);
    axr(OFS_MAP_DATA, d, RESP_OK);
    chk(d, 32'h0);
    // unmapped read and read-only write are refused
    axr(8'h3c, d, RESP_SLVERR);
    chk(d, 32'h0);
    axw(OFS_STATUS, 32'h1, RESP_SLVERR);
    for (int k = 1; k <= 25; k++) begin
      run_case(k);
    end
    complete_run;
  end
endmodule
